//--- src/spicfg_top.sv
// Purpose: Pin steering, baud generation and match/fault flags of a byte-wide SPI
// Assumes: One 25 MHz bus clock ref_clk, synchronous active-low reset, synchronous pins
// Notes:   Avalon-MM slave answers every access with exactly one waitrequest cycle
`timescale 1ns/10ps
`include "spicfg_cfg.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// - Match flag with enable raises interrupt
// - Control two bits 6,5,2 read zero
// - Slave ignores fault enable; select is input
// - Master, fault enable off: select is GPIO
// - Master, fault enable on: fault or output
// - Drive enable gates single-wire data driver
// - Drive enable ignored outside single-wire mode
// - Master shares MOSI, slave shares MISO
// - Halt-in-wait stops interface clocks in wait
// - Two-wire mode uses separate in/out pins
// - Single-wire master leaves MISO unused
// - Single-wire slave leaves MOSI unused
// - Baud register accessible at any time
// - Prescaler divides by field plus one
// - Divider divides by two^(field+1), max 512
// - Serial clock is bus over product
// - Baud generator runs only as master
// - Select output enable picks output or fault
// - Low fault input sets fault flag
// - Match flag after receive-full on equality
module spicfg_top
  import spicfg_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic txBit,
  input wire logic xferActive,
  input wire logic rxDone,
  input wire logic [7:0] rxData,
  input wire logic waitMode,
  input wire logic mosiIn,
  input wire logic misoIn,
  input wire logic ssIn,
  output logic mosiOut,
  output logic mosiOeN,
  output logic misoOut,
  output logic misoOeN,
  output logic ssOut,
  output logic ssOeN,
  output logic ssOwned,
  output logic slaveSel,
  output logic rxBit,
  output logic sck,
  output logic baudTick,
  output logic clkRun,
  output logic matchIrq
);

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Address compare, shared by read mux and write decode
  function automatic logic isReg(input logic [4:0] addr, input logic [4:0] off);
    isReg = (addr == off);
  endfunction

  // Reserved rate codes behave as the slowest legal code
  function automatic logic [3:0] rateCode(input logic [7:0] br);
    logic [3:0] r;
    r = br[`SPICFG_BR_RATE_HI:`SPICFG_BR_RATE_LO];
    rateCode = (r > `SPICFG_RATE_MAX) ? `SPICFG_RATE_MAX : r;
  endfunction

  // Prescaled ticks per half serial period, minus one: 2^code - 1
  function automatic logic [8:0] halfLimit(input logic [3:0] code);
    halfLimit = 9'h0FF >> (`SPICFG_RATE_MAX - code);
  endfunction

  localparam spicfg_pins_s PINS_RST = '{
    mosiOut: 1'b0, mosiOeN: 1'b1, misoOut: 1'b0, misoOeN: 1'b1, ssOut: 1'b1,
    ssOeN: 1'b1, rxBit: 1'b0, slaveSel: 1'b0, ssOwned: 1'b0};

  localparam spicfg_state_s STATE_RST = '{
    ctrl2: `SPICFG_RST_BYTE, baud: `SPICFG_RST_BYTE, cfg: `SPICFG_RST_BYTE,
    matchVal: `SPICFG_RST_BYTE, rxBuf: `SPICFG_RST_BYTE, rxFull: 1'b0,
    matchFlag: 1'b0, faultFlag: 1'b0, rxArm: 1'b0, matchArm: 1'b0, faultArm: 1'b0,
    cmpPend: 1'b0, waitReq: 1'b1, readData: `SPICFG_RST_WORD, preCnt: 3'h0,
    rateCnt: 9'h000, sck: 1'b0, baudTick: 1'b0, matchIrq: 1'b0, clkRun: 1'b1,
    pins: PINS_RST};

  spicfg_state_s s;
  spicfg_state_s next_s;

  logic enable;
  logic master;
  logic single;
  logic driveEn;
  logic faultEn;
  logic selOutEn;
  logic faultInput;
  logic halted;
  logic busReq;
  logic taken;
  logic wrLow;
  logic [2:0] preSel;
  logic [3:0] rateSel;
  logic [7:0] statByte;

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode from current state
  assign enable = s.cfg[`SPICFG_CFG_EN];
  assign master = s.cfg[`SPICFG_CFG_MASTER_SEL];
  assign selOutEn = s.cfg[`SPICFG_CFG_SOE];
  assign single = s.ctrl2[`SPICFG_C2_SWSEL];
  assign driveEn = s.ctrl2[`SPICFG_C2_DRVEN];
  assign faultEn = s.ctrl2[`SPICFG_C2_FAULTEN];
  assign halted = s.ctrl2[`SPICFG_C2_HALT] & waitMode;
  // Fault input only for master, fault enable, no select output
  assign faultInput = enable & master & faultEn & ~selOutEn;
  assign preSel = s.baud[`SPICFG_BR_PRE_HI:`SPICFG_BR_PRE_LO];
  assign rateSel = rateCode(s.baud);
  assign busReq = avs_read | avs_write;
  // Access completes at the edge where waitrequest is seen low
  assign taken = busReq & ~s.waitReq;
  assign wrLow = avs_write & avs_byteenable[0] & taken;
  assign statByte = {s.rxFull, s.matchFlag, 1'b0, s.faultFlag, 4'h0};

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_s = s;
    next_s.baudTick = 1'b0;

    // Bus answer: one wait cycle, then read data stands with waitrequest low
    if (busReq && s.waitReq)
    begin
      next_s.waitReq = 1'b0;
      next_s.readData = `SPICFG_RST_WORD;
      if (isReg(avs_address, `SPICFG_OFF_CTRL2))
        next_s.readData[7:0] = s.ctrl2 & `SPICFG_C2_MASK;
      else if (isReg(avs_address, `SPICFG_OFF_BAUD))
        next_s.readData[7:0] = s.baud;
      else if (isReg(avs_address, `SPICFG_OFF_CFG))
        next_s.readData[7:0] = s.cfg;
      else if (isReg(avs_address, `SPICFG_OFF_STAT))
        next_s.readData[7:0] = statByte;
      else if (isReg(avs_address, `SPICFG_OFF_MATCH))
        next_s.readData[7:0] = s.matchVal;
      else if (isReg(avs_address, `SPICFG_OFF_RXD))
        next_s.readData[7:0] = s.rxBuf;
    end
    else
      next_s.waitReq = 1'b1;

    // Reading status arms the clear of each flag that is set
    if (taken && avs_read && isReg(avs_address, `SPICFG_OFF_STAT))
    begin
      next_s.rxArm = s.rxFull;
      next_s.matchArm = s.matchFlag;
      next_s.faultArm = s.faultFlag;
    end

    // Receive-full clears on armed data read
    if (taken && avs_read && isReg(avs_address, `SPICFG_OFF_RXD) && s.rxArm)
    begin
      next_s.rxFull = 1'b0;
      next_s.rxArm = 1'b0;
    end

    // Register writes; unmapped addresses are ignored
    if (wrLow)
    begin
      if (isReg(avs_address, `SPICFG_OFF_CTRL2))
        next_s.ctrl2 = avs_writedata[7:0] & `SPICFG_C2_MASK;
      // Baud writes accepted in any transfer state
      if (isReg(avs_address, `SPICFG_OFF_BAUD))
        next_s.baud = avs_writedata[7:0] & `SPICFG_BR_MASK;
      if (isReg(avs_address, `SPICFG_OFF_CFG))
      begin
        next_s.cfg = avs_writedata[7:0] & `SPICFG_CFG_MASK;
        if (s.faultArm)
        begin
          next_s.faultFlag = 1'b0;
          next_s.faultArm = 1'b0;
        end
      end
      if (isReg(avs_address, `SPICFG_OFF_MATCH))
        next_s.matchVal = avs_writedata[7:0];
      if (isReg(avs_address, `SPICFG_OFF_STAT) && avs_writedata[`SPICFG_ST_MATCH]
          && s.matchArm)
      begin
        next_s.matchFlag = 1'b0;
        next_s.matchArm = 1'b0;
      end
    end

    // Receive load then compare one cycle later; set wins over clear
    next_s.cmpPend = 1'b0;
    if (rxDone)
    begin
      next_s.rxBuf = rxData;
      next_s.rxFull = 1'b1;
      next_s.cmpPend = 1'b1;
    end
    if (s.cmpPend && s.rxFull && (s.rxBuf == s.matchVal))
      next_s.matchFlag = 1'b1;

    // Low fault input sets the fault flag
    if (faultInput && !ssIn)
      next_s.faultFlag = 1'b1;

    next_s.matchIrq = next_s.matchFlag & next_s.ctrl2[`SPICFG_C2_IRQEN];

    // Clocks stop in wait when halt bit set
    next_s.clkRun = ~halted;

    // Divider runs only as enabled master, not halted
    if (!(enable && master) || halted)
    begin
      next_s.preCnt = 3'h0;
      next_s.rateCnt = 9'h000;
      if (!(enable && master))
        next_s.sck = 1'b0;
    end
    else if (s.preCnt != preSel)
      next_s.preCnt = s.preCnt + 3'h1;
    else
    begin
      next_s.preCnt = 3'h0;
      if (s.rateCnt >= halfLimit(rateSel))
      begin
        next_s.rateCnt = 9'h000;
        next_s.sck = ~s.sck;
        next_s.baudTick = 1'b1;
      end
      else
        next_s.rateCnt = s.rateCnt + 9'h001;
    end

    // Pin steering defaults: nothing driven
    next_s.pins = PINS_RST;
    if (enable)
    begin
      if (master)
      begin
        // Master drives MOSI; shared pin in single-wire
        next_s.pins.mosiOut = txBit;
        // Drive enable only matters in single-wire mode
        next_s.pins.mosiOeN = single ? ~driveEn : 1'b0;
        next_s.pins.rxBit = single ? mosiIn : misoIn;
        // Select pin use by fault and output enables
        next_s.pins.ssOwned = faultEn;
        if (faultEn && selOutEn)
        begin
          next_s.pins.ssOut = ~xferActive;
          next_s.pins.ssOeN = 1'b0;
        end
      end
      else
      begin
        // Slave: select is always an input
        next_s.pins.ssOwned = 1'b1;
        next_s.pins.slaveSel = ~ssIn;
        next_s.pins.misoOut = txBit;
        next_s.pins.misoOeN = single ? ~(driveEn & ~ssIn) : ssIn;
        next_s.pins.rxBit = single ? misoIn : mosiIn;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register, synchronous reset
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      s <= STATE_RST;
    else
      s <= next_s;
  end

  // Outputs straight from the state flops
  assign avs_readdata = s.readData;
  assign avs_waitrequest = s.waitReq;
  assign mosiOut = s.pins.mosiOut;
  assign mosiOeN = s.pins.mosiOeN;
  assign misoOut = s.pins.misoOut;
  assign misoOeN = s.pins.misoOeN;
  assign ssOut = s.pins.ssOut;
  assign ssOeN = s.pins.ssOeN;
  assign ssOwned = s.pins.ssOwned;
  assign slaveSel = s.pins.slaveSel;
  assign rxBit = s.pins.rxBit;
  assign sck = s.sck;
  assign baudTick = s.baudTick;
  assign clkRun = s.clkRun;
  assign matchIrq = s.matchIrq;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions and covers
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // Request and flag register together, so a clear drops both in one edge
  a_match_irq_follow:
    assert property (matchIrq == (s.matchFlag && s.ctrl2[`SPICFG_C2_IRQEN]))
    else $error("Match interrupt not raised");

  a_ctrl2_reserved_zero:
    assert property ((s.ctrl2 & ~`SPICFG_C2_MASK) == 8'h00)
    else $error("Reserved control bits set");

  a_slave_ss_input:
    assert property (enable && !master |=> ssOeN)
    else $error("Slave drove select pin");

  a_master_ss_gpio:
    assert property (enable && master && !faultEn |=> !ssOwned && ssOeN)
    else $error("Select pin not released");

  a_master_ss_out:
    assert property (enable && master && faultEn && selOutEn |=> !ssOeN)
    else $error("Select output not driven");

  a_single_drive_gate:
    assert property (enable && master && single |=> mosiOeN == !$past(driveEn))
    else $error("Shared pin drive mismatch");

  a_two_wire_ignore:
    assert property (enable && master && !single |=> !mosiOeN)
    else $error("Drive enable leaked into two-wire mode");

  a_single_master_miso:
    assert property (enable && master && single |=> misoOeN)
    else $error("MISO used in single-wire master");

  a_single_slave_mosi:
    assert property (enable && !master && single |=> mosiOeN)
    else $error("MOSI used in single-wire slave");

  // Halted as enabled master: no baud tick in the next cycle and the serial clock holds its level
  a_halt_stops_clock:
    assert property (halted && enable && master |=> !baudTick && $stable(sck))
    else $error("Serial clock ran while halted");

  a_slave_no_baud:
    assert property (!master |=> !baudTick)
    else $error("Baud ticks as slave");

  a_fastest_rate:
    assert property (enable && master && !halted && s.baud == 8'h00 && baudTick
      ##1 (enable && master && !halted && s.baud == 8'h00) |-> baudTick)
    else $error("Divide-by-two serial clock wrong");

  a_fault_sets:
    assert property (faultInput && !ssIn |=> s.faultFlag)
    else $error("Fault flag not set");

  a_match_after_rx:
    assert property (rxDone && rxData == s.matchVal && !(wrLow
      && isReg(avs_address, `SPICFG_OFF_MATCH)) ##1 1'b1 |=> s.matchFlag)
    else $error("Match flag missing after receive");

  a_one_wait_cycle:
    assert property (busReq && s.waitReq |=> !avs_waitrequest)
    else $error("Access not answered in one cycle");

  c_match_irq: cover property (matchIrq);
  c_fault: cover property (s.faultFlag);
  c_sck_toggle: cover property (baudTick ##1 !baudTick [*3] ##1 baudTick);
  c_single_slave_drive: cover property (!misoOeN && single);

endmodule

//--- common/spicfg_cfg.svh
// Purpose: Offsets, field positions and reset values of the SPI pin and baud configuration block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only
`ifndef SPICFG_CFG_SVH
`define SPICFG_CFG_SVH

// Register byte offsets
`define SPICFG_OFF_CTRL2 5'h00
`define SPICFG_OFF_BAUD 5'h04
`define SPICFG_OFF_CFG 5'h08
`define SPICFG_OFF_STAT 5'h0C
`define SPICFG_OFF_MATCH 5'h10
`define SPICFG_OFF_RXD 5'h14

// Second control register fields
`define SPICFG_C2_IRQEN 7
`define SPICFG_C2_FAULTEN 4
`define SPICFG_C2_DRVEN 3
`define SPICFG_C2_HALT 1
`define SPICFG_C2_SWSEL 0
`define SPICFG_C2_MASK 8'h9B

// Baud rate register fields
`define SPICFG_BR_PRE_HI 6
`define SPICFG_BR_PRE_LO 4
`define SPICFG_BR_RATE_HI 3
`define SPICFG_BR_RATE_LO 0
`define SPICFG_BR_MASK 8'h7F
`define SPICFG_RATE_MAX 4'h8

// Mode register fields
`define SPICFG_CFG_EN 2
`define SPICFG_CFG_MASTER_SEL 1
`define SPICFG_CFG_SOE 0
`define SPICFG_CFG_MASK 8'h07

// Status register fields
`define SPICFG_ST_RXFULL 7
`define SPICFG_ST_MATCH 6
`define SPICFG_ST_FAULT 4

// Reset values
`define SPICFG_RST_BYTE 8'h00
`define SPICFG_RST_WORD 32'h0000_0000

`endif

//--- common/spicfg_pkg.sv
// Purpose: Types of the SPI pin and baud configuration block
// Assumes: Included by the single design module
// Notes:   All module state is one packed struct
package spicfg_pkg;

  // Pin steering, all registered
  typedef struct packed {
    logic mosiOut;
    logic mosiOeN;
    logic misoOut;
    logic misoOeN;
    logic ssOut;
    logic ssOeN;
    logic rxBit;
    logic slaveSel;
    logic ssOwned;
  } spicfg_pins_s;

  // Whole state of the block
  typedef struct packed {
    logic [7:0] ctrl2;
    logic [7:0] baud;
    logic [7:0] cfg;
    logic [7:0] matchVal;
    logic [7:0] rxBuf;
    logic rxFull;
    logic matchFlag;
    logic faultFlag;
    logic rxArm;
    logic matchArm;
    logic faultArm;
    logic cmpPend;
    logic waitReq;
    logic [31:0] readData;
    logic [2:0] preCnt;
    logic [8:0] rateCnt;
    logic sck;
    logic baudTick;
    logic matchIrq;
    logic clkRun;
    spicfg_pins_s pins;
  } spicfg_state_s;

endpackage

//--- verif/spicfg_peer.sv
// Purpose: Far-side SPI peer that resolves the three shared pins
// Assumes: No pull resistors on the data lines
// Notes:   A released data line shows a level that flips every cycle
`timescale 1ns/10ps
module spicfg_peer
(
  input wire logic ref_clk,
  input wire logic mosiOut,
  input wire logic mosiOeN,
  input wire logic misoOut,
  input wire logic misoOeN,
  input wire logic ssOut,
  input wire logic ssOeN,
  input wire logic ssDrv,
  output logic mosiIn,
  output logic misoIn,
  output logic ssIn
);
  logic flip = 1'b0;
  // Floating filler, so a stale level can never pass for data
  always @(posedge ref_clk)
    flip <= !flip;
  // The block owns a line only while its enable is low
  assign mosiIn = mosiOeN ? flip : mosiOut;
  assign misoIn = misoOeN ? !flip : misoOut;
  assign ssIn = ssOeN ? ssDrv : ssOut;
endmodule

//--- verif/spicfg_tb_top.sv
// Purpose: Self-checking bench for pin steering, baud rate and flags
// Assumes: Avalon master waits for waitrequest low on every access
// Notes:   Expected values come from a small register and pin model
`timescale 1ns/10ps
`include "spicfg_cfg.svh"
module spicfg_tb_top
  import spicfg_pkg::*;
;
  logic ref_clk, rstn, avs_read, avs_write, avs_waitrequest;
  logic [4:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, r;
  logic [3:0] avs_byteenable;
  logic txBit, prevTx, prevMosi, prevMiso, xferActive, rxDone, waitMode, ssDrv;
  logic [7:0] rxData, mv;
  logic mosiIn, misoIn, ssIn, mosiOut, mosiOeN, misoOut, misoOeN;
  logic ssOut, ssOeN, ssOwned, slaveSel, rxBit, sck, baudTick, clkRun, matchIrq;
  int failures, nChecks, seed, n, p, q, m, s, d;
  spicfg_top spicfg_top_inst (.ref_clk(ref_clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .txBit(txBit), .xferActive(xferActive),
    .rxDone(rxDone), .rxData(rxData), .waitMode(waitMode), .mosiIn(mosiIn),
    .misoIn(misoIn), .ssIn(ssIn), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoOut(misoOut), .misoOeN(misoOeN), .ssOut(ssOut), .ssOeN(ssOeN),
    .ssOwned(ssOwned), .slaveSel(slaveSel), .rxBit(rxBit), .sck(sck),
    .baudTick(baudTick), .clkRun(clkRun), .matchIrq(matchIrq));
  spicfg_peer spicfg_peer_inst (.ref_clk(ref_clk), .mosiOut(mosiOut), .mosiOeN(mosiOeN),
    .misoOut(misoOut), .misoOeN(misoOeN), .ssOut(ssOut), .ssOeN(ssOeN), .ssDrv(ssDrv),
    .mosiIn(mosiIn), .misoIn(misoIn), .ssIn(ssIn));
  ////////////////////////////////////////////////////////////////////////////
  // Bus clock, 40 ns period
  always #20 ref_clk = !ref_clk;
  // Random shifter bit, remembered for the registered pin copy
  always @(posedge ref_clk)
  begin
    txBit <= $random(seed);
    prevTx <= txBit;
    // Pin levels as the block sampled them, for the registered input bit
    prevMosi <= mosiIn;
    prevMiso <= misoIn;
  end
  task give_verdict;
    $display("checks %0d failures %0d", nChecks, failures);
    if (failures == 0 && nChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    failures++;
    $display("unexpected wait: expected answer seen none");
    give_verdict();
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // One Avalon access; the request stands until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
    int k;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= !wr;
    for (k = 0; k < 50; k++)
    begin
      @(posedge ref_clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (k == 50)
      hang();
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Cycles up to the next baud tick, bounded
  task automatic tick(output int k);
    for (k = 1; k < 5000; k++)
    begin
      @(posedge ref_clk);
      if (baudTick === 1'b1)
        return;
    end
    hang();
  endtask
  task automatic quiet(output int k);
    k = 0;
    repeat (20)
    begin
      @(posedge ref_clk);
      if (baudTick === 1'b1)
        k++;
    end
  endtask
  task automatic rxByte(input logic [7:0] v);
    @(posedge ref_clk);
    rxData <= v;
    rxDone <= 1'b1;
    @(posedge ref_clk);
    rxDone <= 1'b0;
    repeat (5) @(posedge ref_clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 0; rstn = 0; avs_read = 0; avs_write = 0; avs_address = 0;
    avs_writedata = 0; avs_byteenable = 4'hF; xferActive = 0;
    rxDone = 0; rxData = 0; waitMode = 0; ssDrv = 1; failures = 0; nChecks = 0;
    seed = 32'h7704;
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    bus(0, `SPICFG_OFF_BAUD, 0);
    chk("baud reset", 32'h0000_0000, r);
    bus(1, `SPICFG_OFF_CTRL2, 32'h0000_00FF);
    bus(0, `SPICFG_OFF_CTRL2, 0);
    chk("ctrl2 mask", 32'h0000_009B, r);
    xferActive <= 1'b1;
    bus(1, `SPICFG_OFF_BAUD, 32'h0000_00FF);
    bus(0, `SPICFG_OFF_BAUD, 0);
    chk("baud mid transfer", 32'h0000_007F, r);
    bus(0, 5'h18, 0);
    chk("unmapped", 32'h0000_0000, r);
    // Write without the low byte lane must leave the baud value alone
    avs_byteenable <= 4'hE;
    bus(1, `SPICFG_OFF_BAUD, 32'h0000_0011);
    avs_byteenable <= 4'hF;
    bus(0, `SPICFG_OFF_BAUD, 0);
    chk("baud byteenable", 32'h0000_007F, r);
    xferActive <= 1'b0;
    for (n = 0; n < 8; n++)
    begin
      m = n[2];
      s = n[1];
      d = n[0];
      ssDrv <= 1'b0;
      bus(1, `SPICFG_OFF_CFG, {29'h0, 1'b1, m[0], 1'b0});
      bus(1, `SPICFG_OFF_CTRL2, {28'h0, d[0], 2'h0, s[0]});
      repeat (3) @(posedge ref_clk);
      chk("mosiOeN", m ? (s & !d) : 1, mosiOeN);
      chk("misoOeN", m ? 1 : (s & !d), misoOeN);
      chk("rxBit", (m == s) ? prevMosi : prevMiso, rxBit);
      if (mosiOeN === 1'b0)
        chk("mosiOut", prevTx, mosiOut);
      if (misoOeN === 1'b0)
        chk("misoOut", prevTx, misoOut);
    end
    bus(1, `SPICFG_OFF_CTRL2, 32'h0000_0010);
    bus(1, `SPICFG_OFF_CFG, 32'h0000_0006);
    repeat (3) @(posedge ref_clk);
    bus(0, `SPICFG_OFF_STAT, 0);
    chk("fault flag", 32'h0000_0010, r & 32'h10);
    ssDrv <= 1'b1;
    bus(1, `SPICFG_OFF_CFG, 32'h0000_0007);
    bus(0, `SPICFG_OFF_STAT, 0);
    chk("fault clear", 32'h0, r & 32'h10);
    for (n = 0; n < 2; n++)
    begin
      xferActive <= n[0];
      repeat (3) @(posedge ref_clk);
      chk("ssOeN auto", 1'b0, ssOeN);
      chk("ssOut auto", !n[0], ssOut);
    end
    xferActive <= 1'b0;
    bus(1, `SPICFG_OFF_CTRL2, 32'h0000_0000);
    repeat (3) @(posedge ref_clk);
    chk("ss gpio", 2'b01, {ssOwned, ssOeN});
    for (n = 0; n < 2; n++)
    begin
      bus(1, `SPICFG_OFF_CTRL2, {27'h0, n[0], 4'h0});
      bus(1, `SPICFG_OFF_CFG, 32'h0000_0004);
      ssDrv <= n[0];
      repeat (3) @(posedge ref_clk);
      chk("ss slave", {2'b11, !n[0]}, {ssOwned, ssOeN, slaveSel});
    end
    quiet(q);
    chk("slave ticks", 0, q);
    chk("slave sck", 1'b0, sck);
    bus(1, `SPICFG_OFF_CFG, 32'h0000_0006);
    for (n = 0; n < 6; n++)
    begin
      p = n == 0 ? 0 : n == 1 ? 7 : $unsigned($random(seed)) % 8;
      q = n == 0 ? 0 : n == 1 ? 8 : $unsigned($random(seed)) % 9;
      bus(1, `SPICFG_OFF_BAUD, {25'h0, p[2:0], q[3:0]});
      tick(m);
      tick(m);
      tick(m);
      chk("half period", (p + 1) << q, m);
    end
    bus(1, `SPICFG_OFF_BAUD, 32'h0);
    for (n = 0; n < 2; n++)
    begin
      bus(1, `SPICFG_OFF_CTRL2, {30'h0, n[0], 1'b0});
      waitMode <= 1'b1;
      repeat (3) @(posedge ref_clk);
      chk("clkRun", !n[0], clkRun);
      quiet(q);
      chk("ticks in wait", n ? 0 : 20, q);
      waitMode <= 1'b0;
    end
    mv = $random(seed);
    bus(1, `SPICFG_OFF_MATCH, {24'h0, mv});
    for (n = 0; n < 3; n++)
    begin
      bus(1, `SPICFG_OFF_CTRL2, {24'h0, n != 2, 7'h0});
      rxByte(n == 1 ? mv ^ 8'h01 : mv);
      bus(0, `SPICFG_OFF_STAT, 0);
      chk("match flag", {n != 1, 6'h0}, r & 32'h40);
      chk("matchIrq", n == 0, matchIrq);
      bus(1, `SPICFG_OFF_STAT, 32'h0000_0040);
      repeat (3) @(posedge ref_clk);
      chk("matchIrq clear", 1'b0, matchIrq);
    end
    give_verdict();
  end
endmodule
